// [rtl/ptg_params.svh]
// Constants for the pulse train generator: register offsets, field positions,
// reset values and timing figures. Assumes a 25 MHz system clock.
`ifndef PTG_PARAMS_SVH
`define PTG_PARAMS_SVH

// System clock and the one-microsecond tick derived from it
`define PTG_CLK_HZ 25000000
`define PTG_TICK_NS 1000
`define PTG_TICK_CYC ((`PTG_CLK_HZ / 1000000) * `PTG_TICK_NS / 1000)

// Register byte offsets
`define PTG_OFF_CONFIG 8'h00
`define PTG_OFF_PERIOD 8'h04
`define PTG_OFF_ONDELAY 8'h08
`define PTG_OFF_DUTY 8'h0c
`define PTG_OFF_COUNT 8'h10
`define PTG_OFF_SLOT_VAL 8'h14
`define PTG_OFF_SLOT_CTRL 8'h18
`define PTG_OFF_STATUS 8'h1c
`define PTG_OFF_EMITTED 8'h20
`define PTG_OFF_CURRENT 8'h24

// Configuration field positions
`define PTG_CFG_MODE_LSB 0
`define PTG_CFG_HS_BIT 3
`define PTG_CFG_GATE_BIT 4
`define PTG_CFG_FMT_LSB 5
`define PTG_CFG_DLY_LSB 7
`define PTG_CFG_TWOCH_BIT 11
`define PTG_CFG_SWEN_BIT 12
`define PTG_SLOT_MODE_BIT 4

// Status field positions
`define PTG_ST_ACTIVE 0
`define PTG_ST_PULSE_ERR 1
`define PTG_ST_OUT 2
`define PTG_ST_INPUT 3
`define PTG_ST_SLOT_ERR 4
`define PTG_ST_HS_EFF 5
`define PTG_ST_PARAM_ERR 6

// Reset values
`define PTG_RST_MODE 3'h1
`define PTG_RST_FMT 2'h1
`define PTG_RST_DLY 4'h2
`define PTG_RST_TWOCH 1'b1
`define PTG_RST_PERIOD_US 32'd2000000
`define PTG_RST_ONDELAY_US 32'd0
`define PTG_RST_DUTY 16'd50
`define PTG_RST_COUNT 32'd1

// Value ranges in microseconds
`define PTG_PERIOD_MIN_US 32'd100
`define PTG_PERIOD_MIN_HS_US 32'd10
`define PTG_TIME_MAX_US 32'd85000000

// Duty full scales per format
`define PTG_FS_ANALOG 16'd27648
`define PTG_FS_PCT 16'd100
`define PTG_FS_PERMILLE 16'd1000
`define PTG_FS_PERTENK 16'd10000

// Input stability delays in microseconds
`define PTG_DLY0_US 16'd4
`define PTG_DLY1_US 16'd50
`define PTG_DLY2_US 16'd100
`define PTG_DLY3_US 16'd400
`define PTG_DLY4_US 16'd800
`define PTG_DLY5_US 16'd1600
`define PTG_DLY6_US 16'd3200
`define PTG_DLY7_US 16'd12800
`define PTG_DLY8_US 16'd20000

`endif

// [rtl/ptg_pkg.sv]
// Types shared by the pulse train generator files.
// Assumes ptg_params.svh supplies the numeric constants.
package ptg_pkg;

   // Operating mode selector values
   typedef enum logic [2:0] {
      PTG_MODE_PULSE = 3'h0,
      PTG_MODE_PWM = 3'h1,
      PTG_MODE_TRAIN = 3'h2,
      PTG_MODE_ONOFF = 3'h3,
      PTG_MODE_FREQ = 3'h4,
      PTG_MODE_MOTOR = 3'h5
   } ptg_mode_e;

   // Duty-cycle format selector values
   typedef enum logic [1:0] {
      PTG_FMT_ANALOG = 2'h0,
      PTG_FMT_PCT = 2'h1,
      PTG_FMT_PERMILLE = 2'h2,
      PTG_FMT_PERTENK = 2'h3
   } ptg_fmt_e;

   // Output sequence states
   typedef enum logic [1:0] {
      PTG_IDLE,
      PTG_ONDELAY,
      PTG_RUN
   } ptg_state_e;

   typedef logic [31:0] ptg_word_t;

endpackage : ptg_pkg

// [rtl/ptg_input_filter.sv]
// Debounce filter for the start input of the pulse train generator.
// Assumes a one-cycle tick every microsecond and an input synchronous to clk.
`timescale 1ns/1ps
`include "ptg_params.svh"

module ptg_input_filter (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick_us,
   input wire logic [3:0] delay_code,
   input wire logic din,
   output logic dout_q
);
   import ptg_pkg::*;

   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic dout_d;
   logic [15:0] limit;

   // Stability time for the selected code; unknown codes use the longest delay
   always_comb begin
      case (delay_code)
         4'h0: limit = `PTG_DLY0_US;
         4'h1: limit = `PTG_DLY1_US;
         4'h2: limit = `PTG_DLY2_US;
         4'h3: limit = `PTG_DLY3_US;
         4'h4: limit = `PTG_DLY4_US;
         4'h5: limit = `PTG_DLY5_US;
         4'h6: limit = `PTG_DLY6_US;
         4'h7: limit = `PTG_DLY7_US;
         default: limit = `PTG_DLY8_US;
      endcase
   end

   // Any bounce restarts the count, so only a level held for the full time passes
   always_comb begin
      cnt_d = cnt_q;
      dout_d = dout_q;
      if (din == dout_q) begin
         cnt_d = 16'h0000;
      end else if (tick_us) begin
         if (cnt_q + 16'h0001 >= limit) begin
            dout_d = din;
            cnt_d = 16'h0000;
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 16'h0000;
         dout_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dout_q <= dout_d;
      end
   end

endmodule : ptg_input_filter

// [rtl/ptg_pulse_train.sv]
// Pulse train output channel with its settings registers and value-load port.
// Assumes a single 25 MHz clock, a synchronous start input and a plain register port.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ptg_params.svh"

module ptg_pulse_train (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] bus_addr,
   input wire ptg_pkg::ptg_word_t bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output ptg_pkg::ptg_word_t bus_rdata,
   input wire logic start_input,
   input wire logic [15:0] current_meas,
   output logic pulse_output_pin,
   output logic sequence_active_status
);
   import ptg_pkg::*;

   localparam logic [7:0] TICK_CYC = 8'(`PTG_TICK_CYC);

   // Settings
   ptg_mode_e mode_q, mode_d;
   ptg_fmt_e fmt_q, fmt_d;
   logic hs_q, hs_d, gate_q, gate_d, twoch_q, twoch_d, swen_q, swen_d;
   logic [3:0] dly_q, dly_d;
   ptg_word_t period_q, period_d, ondelay_q, ondelay_d, count_q, count_d;
   logic [15:0] duty_q, duty_d;
   ptg_word_t slot_val_q, slot_val_d;
   logic [3:0] value_load_selector_q, value_load_selector_d;
   logic slot_perm_q, slot_perm_d, slot_err_q, slot_err_d, param_err_q, param_err_d;

   // Sequence state
   ptg_state_e state_q, state_d;
   ptg_word_t t_q, t_d, emitted_q, emitted_d, per_cur_q, per_cur_d, ondly_cur_q, ondly_cur_d;
   logic [15:0] duty_cur_q, duty_cur_d, fs_cur_q, fs_cur_d;
   logic pulse_err_q, pulse_err_d, out_q, out_d, swen_prev_q, gate_prev_q, armed_q, armed_d;
   logic [7:0] div_q, div_d;
   logic tick;
   ptg_word_t rdata_q, rdata_d;
   logic filt_in;
   logic hs_eff;
   ptg_word_t per_min;
   logic start_evt;
   logic [15:0] fs_sel, duty_clamp;

   // One-microsecond tick enable for all timers
   assign tick = (div_q == TICK_CYC - 8'h01);
   assign div_d = tick ? 8'h00 : div_q + 8'h01;

   // Start input qualification
   ptg_input_filter u_filter (
      .clk(clk),
      .rst(rst),
      .tick_us(tick),
      .delay_code(dly_q),
      .din(start_input),
      .dout_q(filt_in)
   );

   // High-speed applies only with two independent channels
   assign hs_eff = hs_q & twoch_q;
   assign per_min = hs_eff ? `PTG_PERIOD_MIN_HS_US : `PTG_PERIOD_MIN_US;

   // Full scale for the selected duty format
   always_comb begin
      case (fmt_q)
         PTG_FMT_ANALOG: fs_sel = `PTG_FS_ANALOG;
         PTG_FMT_PCT: fs_sel = `PTG_FS_PCT;
         PTG_FMT_PERMILLE: fs_sel = `PTG_FS_PERMILLE;
         default: fs_sel = `PTG_FS_PERTENK;
      endcase
   end
   assign duty_clamp = (duty_q > fs_sel) ? fs_sel : duty_q;

   // Start: software enable edge in plain-input mode, or first filtered edge
   // of the hardware start gate while software enable is held
   always_comb begin
      start_evt = 1'b0;
      if (mode_q == PTG_MODE_TRAIN) begin
         if (!gate_q) begin
            start_evt = swen_q & ~swen_prev_q;
         end else begin
            start_evt = swen_q & armed_q & filt_in & ~gate_prev_q;
         end
      end
   end

   // Register writes and value-load handling
   always_comb begin
      mode_d = mode_q;
      fmt_d = fmt_q;
      hs_d = hs_q;
      gate_d = gate_q;
      twoch_d = twoch_q;
      swen_d = swen_q;
      dly_d = dly_q;
      period_d = period_q;
      ondelay_d = ondelay_q;
      duty_d = duty_q;
      count_d = count_q;
      slot_val_d = slot_val_q;
      value_load_selector_d = value_load_selector_q;
      slot_perm_d = slot_perm_q;
      slot_err_d = slot_err_q;
      param_err_d = param_err_q;
      if (bus_wr) begin
         case (bus_addr)
            `PTG_OFF_CONFIG: begin
               mode_d = ptg_mode_e'(bus_wdata[`PTG_CFG_MODE_LSB +: 3]);
               hs_d = bus_wdata[`PTG_CFG_HS_BIT];
               gate_d = bus_wdata[`PTG_CFG_GATE_BIT];
               fmt_d = ptg_fmt_e'(bus_wdata[`PTG_CFG_FMT_LSB +: 2]);
               dly_d = bus_wdata[`PTG_CFG_DLY_LSB +: 4];
               twoch_d = bus_wdata[`PTG_CFG_TWOCH_BIT];
               swen_d = bus_wdata[`PTG_CFG_SWEN_BIT];
            end
            `PTG_OFF_COUNT: count_d = bus_wdata;
            `PTG_OFF_SLOT_VAL: slot_val_d = bus_wdata;
            `PTG_OFF_SLOT_CTRL: begin
               value_load_selector_d = bus_wdata[3:0];
               slot_perm_d = bus_wdata[`PTG_SLOT_MODE_BIT];
            end
            default: ;
         endcase
      end
      // A value is loaded on a control write, and in permanent mode on every value write
      if (bus_wr && (bus_addr == `PTG_OFF_SLOT_CTRL || (bus_addr == `PTG_OFF_SLOT_VAL && slot_perm_q))) begin
         slot_err_d = 1'b0;
         param_err_d = 1'b0;
         case (value_load_selector_d)
            4'h0: ;
            4'h1: begin
               if (slot_val_d >= per_min && slot_val_d <= `PTG_TIME_MAX_US) begin
                  period_d = slot_val_d;
               end else begin
                  param_err_d = 1'b1;
               end
            end
            4'h2: begin
               if (slot_val_d <= `PTG_TIME_MAX_US) begin
                  ondelay_d = slot_val_d;
               end else begin
                  param_err_d = 1'b1;
               end
            end
            4'h4: begin
               if (slot_val_d[31:16] == 16'h0000) begin
                  duty_d = slot_val_d[15:0];
               end else begin
                  param_err_d = 1'b1;
               end
            end
            default: slot_err_d = 1'b1;
         endcase
      end
      // Direct setting writes; period checked against the floor and the maximum, on-delay against the maximum only, duty taken from the low 16 bits unchecked
      if (bus_wr && bus_addr == `PTG_OFF_PERIOD) begin
         if (bus_wdata >= per_min && bus_wdata <= `PTG_TIME_MAX_US) begin
            period_d = bus_wdata;
         end else begin
            param_err_d = 1'b1;
         end
      end
      if (bus_wr && bus_addr == `PTG_OFF_ONDELAY) begin
         if (bus_wdata <= `PTG_TIME_MAX_US) begin
            ondelay_d = bus_wdata;
         end else begin
            param_err_d = 1'b1;
         end
      end
      if (bus_wr && bus_addr == `PTG_OFF_DUTY) begin
         duty_d = bus_wdata[15:0];
      end
   end

   // Output sequence; on-delay and duty are latched at start, the period at
   // each period boundary, while the pulse count is watched every cycle
   always_comb begin
      state_d = state_q;
      t_d = t_q;
      emitted_d = emitted_q;
      per_cur_d = per_cur_q;
      ondly_cur_d = ondly_cur_q;
      duty_cur_d = duty_cur_q;
      fs_cur_d = fs_cur_q;
      pulse_err_d = pulse_err_q;
      armed_d = armed_q;
      out_d = 1'b0;
      if (!gate_q || !swen_q) begin
         armed_d = 1'b1;
      end
      if (start_evt) begin
         armed_d = 1'b0; // Later gate edges are ignored until re-armed
         pulse_err_d = (count_q == 32'h0);
         t_d = 32'h0;
         emitted_d = 32'h0;
         per_cur_d = period_q;
         ondly_cur_d = ondelay_q;
         duty_cur_d = duty_clamp;
         fs_cur_d = fs_sel;
         state_d = (count_q == 32'h0) ? PTG_IDLE : (ondelay_q == 32'h0) ? PTG_RUN : PTG_ONDELAY;
      end else begin
         case (state_q)
            PTG_IDLE: ;
            PTG_ONDELAY: begin
               if (tick) begin
                  if (t_q + 32'h1 >= ondly_cur_q) begin
                     t_d = 32'h0;
                     state_d = PTG_RUN;
                  end else begin
                     t_d = t_q + 32'h1;
                  end
               end
            end
            PTG_RUN: begin
               if (tick) begin
                  if (t_q + 32'h1 >= per_cur_q) begin
                     t_d = 32'h0;
                     emitted_d = emitted_q + 32'h1;
                     per_cur_d = period_q;
                     if (emitted_q + 32'h1 >= count_q) begin
                        state_d = PTG_IDLE;
                     end
                  end else begin
                     t_d = t_q + 32'h1;
                  end
               end
            end
            default: state_d = PTG_IDLE;
         endcase
         // Count dropped to zero or below pulses already sent
         if (state_q != PTG_IDLE && (count_q == 32'h0 || count_q < emitted_q)) begin
            state_d = PTG_IDLE;
            pulse_err_d = 1'b1;
         end
      end
      // Software enable low or leaving train mode cancels the sequence
      if (!swen_q || mode_q != PTG_MODE_TRAIN) begin
         state_d = PTG_IDLE;
      end
      // High while elapsed time times full scale is below duty times period
      if (state_d == PTG_RUN) begin
         out_d = ({16'h0, t_d} * {32'h0, fs_cur_d}) < ({32'h0, duty_cur_d} * {16'h0, per_cur_d});
      end
   end

   // Read data, answered in the cycle after the strobe
   always_comb begin
      rdata_d = 32'h0;
      if (bus_rd) begin
         case (bus_addr)
            `PTG_OFF_CONFIG: begin
               rdata_d[`PTG_CFG_MODE_LSB +: 3] = mode_q;
               rdata_d[`PTG_CFG_HS_BIT] = hs_q;
               rdata_d[`PTG_CFG_GATE_BIT] = gate_q;
               rdata_d[`PTG_CFG_FMT_LSB +: 2] = fmt_q;
               rdata_d[`PTG_CFG_DLY_LSB +: 4] = dly_q;
               rdata_d[`PTG_CFG_TWOCH_BIT] = twoch_q;
               rdata_d[`PTG_CFG_SWEN_BIT] = swen_q;
            end
            `PTG_OFF_PERIOD: rdata_d = period_q;
            `PTG_OFF_ONDELAY: rdata_d = ondelay_q;
            `PTG_OFF_DUTY: rdata_d[15:0] = duty_q;
            `PTG_OFF_COUNT: rdata_d = count_q;
            `PTG_OFF_SLOT_VAL: rdata_d = slot_val_q;
            `PTG_OFF_SLOT_CTRL: rdata_d[4:0] = {slot_perm_q, value_load_selector_q};
            `PTG_OFF_STATUS: begin
               rdata_d[`PTG_ST_ACTIVE] = sequence_active_status;
               rdata_d[`PTG_ST_PULSE_ERR] = pulse_err_q;
               rdata_d[`PTG_ST_OUT] = out_q;
               rdata_d[`PTG_ST_INPUT] = filt_in;
               rdata_d[`PTG_ST_SLOT_ERR] = slot_err_q;
               rdata_d[`PTG_ST_HS_EFF] = hs_eff;
               rdata_d[`PTG_ST_PARAM_ERR] = param_err_q;
            end
            `PTG_OFF_EMITTED: rdata_d = emitted_q;
            `PTG_OFF_CURRENT: rdata_d[15:0] = current_meas;
            default: rdata_d = 32'h0;
         endcase
      end
   end

   // Registers; reset loads every default and parks the output low
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= PTG_MODE_PWM;
         fmt_q <= PTG_FMT_PCT;
         hs_q <= 1'b0;
         gate_q <= 1'b0;
         twoch_q <= `PTG_RST_TWOCH;
         swen_q <= 1'b0;
         dly_q <= `PTG_RST_DLY;
         period_q <= `PTG_RST_PERIOD_US;
         ondelay_q <= `PTG_RST_ONDELAY_US;
         duty_q <= `PTG_RST_DUTY;
         count_q <= `PTG_RST_COUNT;
         slot_val_q <= 32'h0;
         value_load_selector_q <= 4'h0;
         slot_perm_q <= 1'b0;
         slot_err_q <= 1'b0;
         param_err_q <= 1'b0;
         state_q <= PTG_IDLE;
         t_q <= 32'h0;
         emitted_q <= 32'h0;
         per_cur_q <= `PTG_RST_PERIOD_US;
         ondly_cur_q <= `PTG_RST_ONDELAY_US;
         duty_cur_q <= `PTG_RST_DUTY;
         fs_cur_q <= `PTG_FS_PCT;
         pulse_err_q <= 1'b0;
         out_q <= 1'b0;
         swen_prev_q <= 1'b0;
         gate_prev_q <= 1'b0;
         armed_q <= 1'b1;
         div_q <= 8'h00;
         rdata_q <= 32'h0;
      end else begin
         mode_q <= mode_d;
         fmt_q <= fmt_d;
         hs_q <= hs_d;
         gate_q <= gate_d;
         twoch_q <= twoch_d;
         swen_q <= swen_d;
         dly_q <= dly_d;
         period_q <= period_d;
         ondelay_q <= ondelay_d;
         duty_q <= duty_d;
         count_q <= count_d;
         slot_val_q <= slot_val_d;
         value_load_selector_q <= value_load_selector_d;
         slot_perm_q <= slot_perm_d;
         slot_err_q <= slot_err_d;
         param_err_q <= param_err_d;
         state_q <= state_d;
         t_q <= t_d;
         emitted_q <= emitted_d;
         per_cur_q <= per_cur_d;
         ondly_cur_q <= ondly_cur_d;
         duty_cur_q <= duty_cur_d;
         fs_cur_q <= fs_cur_d;
         pulse_err_q <= pulse_err_d;
         out_q <= out_d;
         swen_prev_q <= swen_q;
         gate_prev_q <= filt_in;
         armed_q <= armed_d;
         div_q <= div_d;
         rdata_q <= rdata_d;
      end
   end

   assign bus_rdata = rdata_q;
   assign pulse_output_pin = out_q;
   assign sequence_active_status = (state_q != PTG_IDLE);

endmodule : ptg_pulse_train

// [tb/ptg_pulse_train_props.sv]
// Port assertions for the pulse train channel.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ptg_pulse_train_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] bus_addr,
   input wire ptg_pkg::ptg_word_t bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire ptg_pkg::ptg_word_t bus_rdata,
   input wire logic start_input,
   input wire logic [15:0] current_meas,
   input wire logic pulse_output_pin,
   input wire logic sequence_active_status
);
   import ptg_pkg::*;
   logic pin_q;
   logic [15:0] gap_q;
   default clocking dcb @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles since the last pin rise; saturated outside a sequence so a first rise after on-delay passes
   always_ff @(posedge clk) begin
      pin_q <= pulse_output_pin;
      if (rst || !sequence_active_status) begin
         gap_q <= 16'hffff;
      end else if (pulse_output_pin && !pin_q) begin
         gap_q <= 16'h0000;
      end else if (gap_q != 16'hffff) begin
         gap_q <= gap_q + 16'h0001;
      end
   end
   rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   current_read_a: assert property (bus_rd && bus_addr == 8'h24 |=> bus_rdata == {16'h0, $past(current_meas)})
      else $error("current reading wrong");
   status_read_a: assert property (bus_rd && bus_addr == 8'h1c |=>
      bus_rdata[0] == $past(sequence_active_status) && bus_rdata[2] == $past(pulse_output_pin))
      else $error("status reading wrong");
   unmapped_read_a: assert property (bus_rd && (bus_addr > 8'h24 || bus_addr[1:0] != 2'h0) |=> bus_rdata == 32'h0)
      else $error("unmapped read not zero");
   pin_in_seq_a: assert property (pulse_output_pin |-> sequence_active_status)
      else $error("pin high outside a sequence");
   reset_quiet_a: assert property (disable iff (1'b0) rst |=>
      !pulse_output_pin && !sequence_active_status && bus_rdata == 32'h0)
      else $error("outputs not quiet after reset");
   cancel_seq_a: assert property (bus_wr && bus_addr == 8'h00 && (bus_wdata[2:0] != 3'h2 || !bus_wdata[12])
      |-> ##2 !sequence_active_status && !pulse_output_pin)
      else $error("sequence not cancelled");
   count_zero_a: assert property (bus_wr && bus_addr == 8'h10 && bus_wdata == 32'h0
      |-> ##3 !sequence_active_status && !pulse_output_pin)
      else $error("zero count did not end sequence");
   period_floor_a: assert property (pulse_output_pin && !pin_q |-> gap_q >= 16'd249)
      else $error("pulse period below floor");
   cover property ($rose(sequence_active_status));
   cover property ($rose(pulse_output_pin));
   cover property ($fell(sequence_active_status));
   cover property (bus_wr && bus_addr == 8'h10 && bus_wdata == 32'h0 && sequence_active_status);
endmodule : ptg_pulse_train_props
bind ptg_pulse_train ptg_pulse_train_props u_props (.clk(clk), .rst(rst), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .start_input(start_input),
   .current_meas(current_meas), .pulse_output_pin(pulse_output_pin), .sequence_active_status(sequence_active_status));

// [tb/ptg_ctrl_model.sv]
// Controller and field-side model: register port master, start input, current sensor.
// Assumes read data arrive in the cycle after the read strobe.
`timescale 1ns/1ps
module ptg_ctrl_model (
   input wire logic clk,
   output logic [7:0] bus_addr,
   output ptg_pkg::ptg_word_t bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire ptg_pkg::ptg_word_t bus_rdata,
   output logic start_input,
   output logic [15:0] current_meas
);
   import ptg_pkg::*;
   // Quiet bus at time zero
   initial begin
      bus_addr = 8'h00;
      bus_wdata = 32'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      start_input = 1'b0;
      current_meas = 16'h0000;
   end
   // One write cycle; released lines show the inverse so stale values never match
   task automatic wr(input logic [7:0] a, input ptg_word_t d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
   endtask : wr
   // One read cycle; data taken mid-cycle of the answer
   task automatic rd(input logic [7:0] a, output ptg_word_t d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      @(negedge clk);
      d = bus_rdata;
   endtask : rd
   task automatic set_in(input logic v);
      @(posedge clk);
      start_input <= v;
   endtask : set_in
   task automatic set_cur(input logic [15:0] v);
      @(posedge clk);
      current_meas <= v;
   endtask : set_cur
endmodule : ptg_ctrl_model

// [tb/ptg_pulse_train_tb.sv]
// Self-checking bench for the pulse train channel.
// Assumes the controller model and the bound checker; 100 us periods keep runs short.
`timescale 1ns/1ps
module ptg_pulse_train_tb;
   import ptg_pkg::*;
   typedef struct packed {logic [1:0] fmt; logic [15:0] duty; logic [7:0] hi_us;} ptg_row_s;
   logic clk;
   logic rst;
   logic [7:0] bus_addr;
   ptg_word_t bus_wdata;
   ptg_word_t bus_rdata;
   logic bus_wr;
   logic bus_rd;
   logic start_input;
   logic [15:0] current_meas;
   logic pin;
   logic act;
   int err_count;
   int comparisons;
   int n;
   int k;
   // Format, duty value, expected high time in us
   ptg_row_s rows [5] = '{'{2'h0, 16'd13824, 8'd50}, '{2'h1, 16'd25, 8'd25}, '{2'h1, 16'd200, 8'd100},
      '{2'h2, 16'd750, 8'd75}, '{2'h3, 16'd1000, 8'd10}};
   ptg_pulse_train dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .start_input(start_input), .current_meas(current_meas),
      .pulse_output_pin(pin), .sequence_active_status(act));
   ptg_ctrl_model u_ctrl (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .start_input(start_input), .current_meas(current_meas));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Tolerance covers the one-tick jitter of the microsecond counter
   task automatic chk(input string what, input ptg_word_t exp, input ptg_word_t got, input int tol);
      comparisons++;
      if (got !== exp && (tol == 0 || $isunknown(got) || got > exp + tol || got + tol < exp)) begin
         err_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk
   task automatic rc(input logic [7:0] a, input string what, input ptg_word_t exp);
      ptg_word_t v;
      u_ctrl.rd(a, v);
      chk(what, exp, v, 0);
   endtask : rc
   function automatic ptg_word_t cfg(input logic [2:0] m, input logic g, input logic hs, input logic tw,
      input logic [3:0] dl, input logic en);
      return {19'h0, en, tw, dl, 2'h1, g, hs, m};
   endfunction : cfg
   // Enable edge 0 to 1 starts a sequence in plain-input mode
   task automatic start(input logic [1:0] f);
      u_ctrl.wr(8'h00, {19'h0, 1'b0, 1'b1, 4'h2, f, 2'h0, 3'h2});
      u_ctrl.wr(8'h00, {19'h0, 1'b1, 1'b1, 4'h2, f, 2'h0, 3'h2});
   endtask : start
   // k counts cycles until the pin rises, c the cycles it stays high
   task automatic hi_time(output int c);
      c = 0;
      k = 0;
      while (pin !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      while (pin === 1'b1 && c < 3000) begin
         @(negedge clk);
         c++;
      end
   endtask : hi_time
   // Counts pin rises until the sequence ends
   task automatic pulses(output int r);
      logic p;
      r = 0;
      p = pin;
      for (int i = 0; i < 20000 && act === 1'b1; i++) begin
         @(negedge clk);
         if (pin === 1'b1 && p === 1'b0) r++;
         p = pin;
      end
   endtask : pulses
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #2000000;
      err_count++;
      report_and_stop();
   end
   initial begin
      err_count = 0;
      comparisons = 0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // One single-pulse train per row
      foreach (rows[i]) begin
         u_ctrl.wr(8'h04, 32'd100);
         u_ctrl.wr(8'h0c, {16'h0, rows[i].duty});
         u_ctrl.wr(8'h10, 32'd1);
         start(rows[i].fmt);
         hi_time(n);
         chk("high cycles", rows[i].hi_us * 25, n, 26);
         pulses(n);
         $display("test row %0d finished", i);
      end
      // Second reset mid-run, then defaults
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rc(8'h00, "config", 32'h921);
      rc(8'h04, "period", 32'd2000000);
      rc(8'h08, "on-delay", 32'd0);
      rc(8'h0c, "duty", 32'd50);
      rc(8'h10, "count", 32'd1);
      rc(8'h1c, "status", 32'h0);
      rc(8'h28, "unmapped", 32'h0);
      $display("test defaults finished");
      // Count raised then lowered while running
      u_ctrl.wr(8'h04, 32'd100);
      u_ctrl.wr(8'h10, 32'd3);
      start(2'h1);
      u_ctrl.set_cur(16'h1234);
      rc(8'h24, "current", 32'h1234);
      u_ctrl.wr(8'h10, 32'd2);
      pulses(n);
      chk("later pulses", 1, n, 0);
      rc(8'h1c, "status end", 32'h0);
      u_ctrl.wr(8'h10, 32'd3);
      start(2'h1);
      repeat (5100) @(negedge clk);
      u_ctrl.wr(8'h10, 32'd1);
      rc(8'h1c, "status below", 32'h2);
      u_ctrl.wr(8'h10, 32'd4);
      start(2'h1);
      rc(8'h1c, "status restart", 32'h5);
      u_ctrl.wr(8'h10, 32'd0);
      rc(8'h1c, "status zero", 32'h2);
      $display("test count finished");
      // Value loads, range refusals, on-delay
      u_ctrl.wr(8'h14, 32'd20);
      u_ctrl.wr(8'h18, 32'h2);
      rc(8'h08, "loaded delay", 32'd20);
      u_ctrl.wr(8'h10, 32'd1);
      start(2'h1);
      hi_time(n);
      chk("delay cycles", 500, k, 26);
      pulses(n);
      u_ctrl.wr(8'h04, 32'd50);
      rc(8'h04, "period kept", 32'd100);
      rc(8'h1c, "param err", 32'h40);
      u_ctrl.wr(8'h18, 32'h3);
      rc(8'h1c, "select err", 32'h10);
      u_ctrl.wr(8'h00, cfg(3'h2, 1'b0, 1'b1, 1'b0, 4'h2, 1'b0));
      u_ctrl.wr(8'h04, 32'd50);
      rc(8'h04, "one channel", 32'd100);
      u_ctrl.wr(8'h00, cfg(3'h2, 1'b0, 1'b1, 1'b1, 4'h2, 1'b0));
      u_ctrl.wr(8'h14, 32'd50);
      u_ctrl.wr(8'h18, 32'h1);
      rc(8'h04, "fast period", 32'd50);
      u_ctrl.wr(8'h18, 32'h14);
      u_ctrl.wr(8'h14, 32'd30);
      rc(8'h0c, "lasting duty", 32'd30);
      $display("test loads finished");
      // Other mode idle; gated start after the filter delay of code 1
      u_ctrl.wr(8'h04, 32'd100);
      u_ctrl.wr(8'h00, cfg(3'h1, 1'b0, 1'b0, 1'b1, 4'h2, 1'b1));
      repeat (100) @(negedge clk);
      chk("other mode", 0, act, 0);
      u_ctrl.wr(8'h00, cfg(3'h2, 1'b1, 1'b0, 1'b1, 4'h1, 1'b1));
      repeat (100) @(negedge clk);
      chk("gate waits", 0, act, 0);
      u_ctrl.set_in(1'b1);
      repeat (1200) @(negedge clk);
      chk("filter holds", 0, act, 0);
      repeat (100) @(negedge clk);
      chk("gate start", 1, act, 0);
      u_ctrl.set_in(1'b0);
      $display("test gate finished");
      report_and_stop();
   end
endmodule : ptg_pulse_train_tb
